// ### reset_strap_option_latch.sv
`timescale 1ns/1ps
`default_nettype none
module reset_strap_option_latch #(
  parameter int HOLD_CYCLES = strap_pkg::HANDBACK_CYCLES
) (
  // clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  reset_n_i,
  // strap pads (input side)
  input  wire logic [6:0]            strap_pins_i,
  input  wire logic                  id_is_zero_i,
  // config register write requests
  input  wire logic                  sys_cfg_wr_i,
  input  wire logic                  sdram_cfg_wr_i,
  // mode settings, hand-back flag and config write permissions
  output strap_pkg::strap_mode_t     mode_o,
  output logic                       ext_int_edge_o,
  output logic                       pins_normal_o,
  output logic                       sys_cfg_wr_ok_o,
  output logic                       sdram_cfg_wr_ok_o,
  // pad pulls and drive enables, one per strap pin
  output strap_pkg::pad_pull_t [6:0] pad_pull_o,
  output logic [6:0]                 pad_drive_en_o
);

  localparam int CNT_W    = strap_pkg::HOLD_CNT_W;
  localparam int HOLD_MAX = (1 << CNT_W) - 1;
  localparam int HB_DLY   = HOLD_CYCLES + 1;

  // the counter width caps the delay; zero would hand the pins back on the same edge as the capture
  if (HOLD_CYCLES < 1 || HOLD_CYCLES > HOLD_MAX) begin : g_bad_hold
    $error("HOLD_CYCLES out of range");
  end

  logic                  rst_s1_ff;
  logic                  rst_s2_ff;
  logic [6:0]            pin_s1_ff;
  logic [6:0]            pin_s2_ff;
  logic                  id_s1_ff;
  logic                  id_s2_ff;
  logic [6:0]            strap_ff;
  logic                  rel_d_ff;
  logic [CNT_W-1:0]      hold_cnt_ff;
  logic                  normal_ff;
  logic                  sys_used_ff;
  logic                  sdram_used_ff;
  logic                  rel_pulse;

  // reset release through two flops
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end

  // pins come from the board, so synchronise before sampling
  always_ff @(posedge sys_clk_i) begin
    pin_s1_ff <= strap_pins_i;
    pin_s2_ff <= pin_s1_ff;
    id_s1_ff  <= id_is_zero_i;
    id_s2_ff  <= id_s1_ff;
  end

  // release edge seen by the clocked domain; the pins are still in strap mode here
  always_ff @(posedge sys_clk_i or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      rel_d_ff <= 1'b0;
    end else begin
      rel_d_ff <= rst_s2_ff;
    end
  end
  assign rel_pulse = rst_s2_ff && !rel_d_ff;

  // capture at release, defaults during reset, frozen otherwise
  always_ff @(posedge sys_clk_i or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      strap_ff <= strap_pkg::STRAP_DEFAULT;
    end else if (rel_pulse) begin
      strap_ff <= pin_s2_ff;
    end
  end

  // hand-back timer
  always_ff @(posedge sys_clk_i or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      hold_cnt_ff <= '0;
      normal_ff   <= 1'b0;
    end else if (rst_s2_ff && !normal_ff) begin
      if (hold_cnt_ff == CNT_W'(HOLD_CYCLES)) begin
        normal_ff <= 1'b1;
      end else begin
        hold_cnt_ff <= hold_cnt_ff + CNT_W'(1);
      end
    end
  end

  // one-time write tracking for the two config registers
  always_ff @(posedge sys_clk_i or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      sys_used_ff   <= 1'b0;
      sdram_used_ff <= 1'b0;
    end else begin
      if (sys_cfg_wr_i && normal_ff) sys_used_ff <= 1'b1;
      if (sdram_cfg_wr_i && normal_ff) sdram_used_ff <= 1'b1;
    end
  end

  always_comb begin
    mode_o.wait_ext_boot = strap_ff[strap_pkg::BOOT_BIT];
    mode_o.int_level_en  = strap_ff[strap_pkg::INT_BIT];
    mode_o.link_rx_4bit  = strap_ff[strap_pkg::WIDTH_BIT];
    mode_o.cfg_always_wr = strap_ff[strap_pkg::LOCK_BIT];
    // a low test strap means the board broke the pull-up
    mode_o.test_mode     = ~&strap_ff[strap_pkg::TEST3_BIT:strap_pkg::TEST1_BIT];
  end
  assign ext_int_edge_o    = ~strap_ff[strap_pkg::INT_BIT];
  assign pins_normal_o     = normal_ff;
  assign sys_cfg_wr_ok_o   = normal_ff && (strap_ff[strap_pkg::LOCK_BIT] || !sys_used_ff);
  assign sdram_cfg_wr_ok_o = normal_ff && (strap_ff[strap_pkg::LOCK_BIT] || !sdram_used_ff);

  // pad resistors follow the synchronised reset state
  always_comb begin
    for (int i = 0; i < strap_pkg::STRAP_W; i++) begin
      pad_pull_o[i]     = '0;
      pad_drive_en_o[i] = 1'b0;
      if (i == strap_pkg::BOOT_BIT || i == strap_pkg::LOCK_BIT) begin
        // id-zero pads are never driven by this block
        pad_pull_o[i].pull_down = !rst_s2_ff && id_s2_ff;
        pad_pull_o[i].pull_up   = rst_s2_ff && id_s2_ff;
      end else if (i == strap_pkg::INT_BIT || i == strap_pkg::WIDTH_BIT) begin
        pad_pull_o[i].pull_down = !rst_s2_ff;
        pad_drive_en_o[i]       = normal_ff;
      end else begin
        pad_pull_o[i].pull_up = !rst_s2_ff;
        pad_drive_en_o[i]     = normal_ff;
      end
    end
  end

  // straps move only at the release pulse
  property p_hold;
    @(posedge sys_clk_i) disable iff (!rst_s2_ff)
      !rel_pulse |=> $stable(strap_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("strap changed outside release");

  property p_capture;
    @(posedge sys_clk_i) disable iff (!rst_s2_ff)
      rel_pulse |=> strap_ff == $past(pin_s2_ff);
  endproperty
  a_capture: assert property (p_capture) else $error("strap not captured");

  property p_handback;
    @(posedge sys_clk_i) disable iff (!rst_s2_ff)
      rel_pulse |-> ##HB_DLY normal_ff;
  endproperty
  a_handback: assert property (p_handback) else $error("pins not handed back");

  // the pins must still read as straps while the capture lands
  property p_handback_early;
    @(posedge sys_clk_i) disable iff (!rst_s2_ff)
      rel_pulse |-> !normal_ff ##1 !normal_ff;
  endproperty
  a_handback_early: assert property (p_handback_early) else $error("pins handed back too early");

  property p_lock;
    @(posedge sys_clk_i) disable iff (!rst_s2_ff)
      (sys_cfg_wr_i && sys_cfg_wr_ok_o && !strap_ff[strap_pkg::LOCK_BIT]) |=> !sys_cfg_wr_ok_o;
  endproperty
  a_lock: assert property (p_lock) else $error("config written twice");

  property p_sdram_lock;
    @(posedge sys_clk_i) disable iff (!rst_s2_ff)
      (sdram_cfg_wr_i && sdram_cfg_wr_ok_o && !strap_ff[strap_pkg::LOCK_BIT]) |=> !sdram_cfg_wr_ok_o;
  endproperty
  a_sdram_lock: assert property (p_sdram_lock) else $error("sdram config written twice");

  property p_wr_gate;
    @(posedge sys_clk_i) disable iff (!rst_s2_ff)
      !normal_ff |-> !sys_cfg_wr_ok_o && !sdram_cfg_wr_ok_o;
  endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("config write open before hand-back");

  property p_nodrive;
    @(posedge sys_clk_i) disable iff (!rst_s2_ff)
      !normal_ff |-> pad_drive_en_o == '0;
  endproperty
  a_nodrive: assert property (p_nodrive) else $error("pad driven during strap");

  // no disable here: this one watches the reset phase itself
  property p_pull_rst;
    @(posedge sys_clk_i)
      !rst_s2_ff |-> pad_pull_o[strap_pkg::INT_BIT].pull_down && pad_pull_o[strap_pkg::TEST1_BIT].pull_up
                     && !pad_pull_o[strap_pkg::TEST1_BIT].pull_down && pad_drive_en_o == '0;
  endproperty
  a_pull_rst: assert property (p_pull_rst) else $error("reset pulls wrong");

  property p_pull_run;
    @(posedge sys_clk_i) disable iff (!rst_s2_ff)
      normal_ff |-> pad_drive_en_o[strap_pkg::INT_BIT] && !pad_pull_o[strap_pkg::INT_BIT].pull_down
                    && !pad_pull_o[strap_pkg::TEST1_BIT].pull_up && !pad_drive_en_o[strap_pkg::BOOT_BIT];
  endproperty
  a_pull_run: assert property (p_pull_run) else $error("run pulls wrong");

  property p_mode_stable;
    @(posedge sys_clk_i) disable iff (!rst_s2_ff)
      normal_ff |=> $stable(mode_o);
  endproperty
  a_mode_stable: assert property (p_mode_stable) else $error("mode moved in normal operation");

  c_release: cover property (@(posedge sys_clk_i) rel_pulse ##[1:20] normal_ff);
  c_test: cover property (@(posedge sys_clk_i) mode_o.test_mode && normal_ff);
  c_extboot: cover property (@(posedge sys_clk_i) mode_o.wait_ext_boot && normal_ff);
  c_lock: cover property (@(posedge sys_clk_i) sys_cfg_wr_i ##1 !sys_cfg_wr_ok_o);

endmodule
`default_nettype wire

// ### strap_pkg.sv
package strap_pkg;

  // strap pin positions within the sampled vector
  localparam int STRAP_W        = 7;
  localparam int BOOT_BIT       = 0;
  localparam int INT_BIT        = 1;
  localparam int WIDTH_BIT      = 2;
  localparam int LOCK_BIT       = 3;
  localparam int TEST1_BIT      = 4;
  localparam int TEST2_BIT      = 5;
  localparam int TEST3_BIT      = 6;

  // default levels set by the reset-time pulls (tests pulled up)
  localparam logic [6:0] STRAP_DEFAULT = 7'h70;

  // cycles after release before the pins return to normal use
  localparam int HANDBACK_NS     = 200;
  localparam int CLK_PERIOD_NS   = 100;
  localparam int HANDBACK_CYCLES = (HANDBACK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CNT_W      = 8;

  // captured mode settings
  typedef struct packed {
    logic wait_ext_boot;
    logic int_level_en;
    logic link_rx_4bit;
    logic cfg_always_wr;
    logic test_mode;
  } strap_mode_t;

  // pad resistor control for one pad
  typedef struct packed {
    logic pull_up;
    logic pull_down;
  } pad_pull_t;

endpackage

// ### strap_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module strap_board_model (
  // clock and pad state
  input  wire logic                       clk_i,
  input  wire strap_pkg::pad_pull_t [6:0] pad_pull_i,
  // board straps
  input  wire logic [6:0]                 ext_en_i,
  input  wire logic [6:0]                 ext_lvl_i,
  // pad levels
  output logic [6:0]                      pin_o
);
  logic [6:0] tgl_ff = 7'h55;
  always_ff @(posedge clk_i) begin
    tgl_ff <= ~tgl_ff;
  end
  // a pad left floating wanders, so nothing may lean on a settled value
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (ext_en_i[i]) begin
        pin_o[i] = ext_lvl_i[i];
      end else if (pad_pull_i[i].pull_up | pad_pull_i[i].pull_down) begin
        pin_o[i] = pad_pull_i[i].pull_up;
      end else begin
        pin_o[i] = tgl_ff[i];
      end
    end
  end
endmodule
`default_nettype wire

// ### reset_strap_option_latch_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module reset_strap_option_latch_tb_top;
  logic                       clk = 1'h0, rst_n = 1'h0, id0 = 1'h1, swr = 1'h0, dwr = 1'h0;
  logic [6:0]                 en = 7'h00, lvl = 7'h00, pins, drv;
  logic                       edge_n, normal, sok, dok;
  strap_pkg::strap_mode_t     mode;
  strap_pkg::pad_pull_t [6:0] pull;
  int                         n_mismatch = 0, num_checks = 0;
  always #50 clk = ~clk;
  reset_strap_option_latch i_reset_strap_option_latch (.sys_clk_i(clk), .reset_n_i(rst_n), .strap_pins_i(pins),
    .id_is_zero_i(id0), .sys_cfg_wr_i(swr), .sdram_cfg_wr_i(dwr), .mode_o(mode), .ext_int_edge_o(edge_n),
    .pins_normal_o(normal), .sys_cfg_wr_ok_o(sok), .sdram_cfg_wr_ok_o(dok), .pad_pull_o(pull),
    .pad_drive_en_o(drv));
  strap_board_model i_strap_board_model (.clk_i(clk), .pad_pull_i(pull), .ext_en_i(en), .ext_lvl_i(lvl),
    .pin_o(pins));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // one reset cycle with given board straps, then run-time checks
  task automatic strap_case(input logic [6:0] e, input logic [6:0] l, input logic z);
    logic [6:0] eff;
    logic [4:0] m;
    @(negedge clk);
    rst_n = 1'h0;
    en = e;
    lvl = l;
    id0 = z;
    repeat (8) @(negedge clk);
    chk("pull_rst", 16'h2a14 | (z ? 16'h0041 : 16'h0000), 16'(pull));
    chk("drv_rst", 16'h0000, 16'(drv));
    rst_n = 1'h1;
    for (int i = 0; i < 20 && normal !== 1'h1; i++) @(negedge clk);
    chk("normal", 16'h0001, 16'(normal));
    chk("pull_run", z ? 16'h0082 : 16'h0000, 16'(pull));
    chk("drv_run", 16'h0076, 16'(drv));
    eff = (e & l) | (~e & strap_pkg::STRAP_DEFAULT);
    m = {eff[0], eff[1], eff[2], eff[3], ~&eff[6:4]};
    chk("mode", 16'(m), 16'(mode));
    chk("edge", 16'(!eff[1]), 16'(edge_n));
    // driving every pin to the inverse of its board level after capture must leave the modes alone
    lvl = ~l;
    en = 7'h7f;
    repeat (4) @(negedge clk);
    chk("hold", 16'(m), 16'(mode));
    chk("wr_ok", 16'h0003, 16'({sok, dok}));
    swr = 1'h1;
    @(negedge clk);
    swr = 1'h0;
    @(negedge clk);
    chk("sys_wr", 16'({eff[3], 1'h1}), 16'({sok, dok}));
    dwr = 1'h1;
    @(negedge clk);
    dwr = 1'h0;
    @(negedge clk);
    chk("sdr_wr", 16'({eff[3], eff[3]}), 16'({sok, dok}));
  endtask
  initial begin
    strap_case(7'h00, 7'h00, 1'h1);
    strap_case(7'h0f, 7'h0f, 1'h1);
    strap_case(7'h0a, 7'h0a, 1'h1);
    strap_case(7'h20, 7'h00, 1'h1);
    strap_case(7'h7f, 7'h75, 1'h0);
    finish_test();
  end
  initial begin
    repeat (2000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
endmodule
`default_nettype wire
